// ### include/port_power_pkg.sv
// Shared constants for the downstream port power and over-current block.
// Assumes a single 20 MHz core clock and word-wide register access.
package port_power_pkg;

  localparam int NPORTS = 6;

  // Clock and the common millisecond tick
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_LOCKOUT = 14'h30e1;
  localparam logic [13:0] IDX_MIN_WIDTH = 14'h30ea;
  localparam logic [13:0] IDX_INACTIVE = 14'h30eb;
  localparam logic [13:0] IDX_CTRL = 14'h3100;
  localparam logic [13:0] IDX_POWER = 14'h3101;
  localparam logic [13:0] IDX_CHARGE = 14'h3102;
  localparam logic [13:0] IDX_STATUS = 14'h3103;
  localparam logic [13:0] IDX_MASK = 14'h3104;
  localparam logic [13:0] IDX_PINS = 14'h3105;

  // Control register fields and the on-bit position in the pins register
  localparam int CTRL_GANG_BIT = 0;
  localparam int CTRL_CPU_BIT = 1;
  localparam int PINS_ON_POS = 8;

  // Values after reset and the min width limit
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] MIN_WIDTH_RST = 4'h5;
  localparam logic [3:0] MIN_WIDTH_MAX = 4'h5;
  localparam logic [7:0] INACTIVE_RST = 8'h14;
  localparam logic [7:0] LOCKOUT_RST = 8'h0a;

endpackage

// ### rtl/ms_tick.sv
// Free-running divider giving a one-cycle pulse every millisecond.
// Assumes clk runs continuously out of reset.
module ms_tick #(
  parameter int CYCLES = port_power_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Tick out
  output logic tick
);
  import port_power_pkg::*;

  localparam int W = (CYCLES > 2) ? $clog2(CYCLES) : 1;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } tick_s;

  tick_s q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == W'(CYCLES - 1)) begin
      d.cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

  property p_tick_wrap;
    @(posedge clk) disable iff (rst)
    q.tick |-> q.cnt == '0 && $past(q.cnt) == W'(CYCLES - 1);
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("tick not on counter wrap");

endmodule

// ### rtl/port_fault_filter.sv
// Over-current filter for one power/sense pin.
// Assumes the pin level is synchronous-ish and a one-millisecond tick pulse.
module port_fault_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timing
  input wire logic tick,
  input wire logic [3:0] min_width,
  input wire logic [7:0] window,
  input wire logic [7:0] lockout,
  // Pin and power state
  input wire logic pin_i,
  input wire logic powered,
  // Results
  output logic fault,
  output logic level
);
  import port_power_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pwr;
    logic [7:0] lock;
    logic [2:0] warm;
    logic [3:0] low_ms;
    logic [7:0] win;
    logic tripped;
    logic fault;
  } filt_s;

  filt_s q, d;
  logic low;
  logic fall;
  logic rise;

  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.prev = q.s2;
    d.pwr = powered;
    d.fault = 1'b0;
    low = ~q.s2;
    fall = ~q.s2 & q.prev;
    rise = q.s2 & ~q.prev;
    if (!powered) begin
      d.lock = '0;
      d.warm = '0;
      d.low_ms = '0;
      d.win = '0;
      d.tripped = 1'b0;
    end else if (!q.pwr) begin
      // Power just applied: start the lockout
      d.lock = lockout;
      d.warm = '0;
      d.low_ms = '0;
      d.win = '0;
    end else if (q.lock != 8'h0 || !(&q.warm)) begin
      // Sync stages still carry the driven-low level from power off
      d.warm = {q.warm[1:0], 1'b1};
      if (tick && q.lock != 8'h0) begin
        d.lock = q.lock - 8'h1;
      end
      d.low_ms = '0;
      d.win = '0;
    end else if (!q.tripped) begin
      // Low must persist min_width ticks, but a short fall within the window after a rise still counts
      if (low) begin
        if (tick && q.low_ms != 4'hf) begin
          d.low_ms = q.low_ms + 4'h1;
        end
      end else begin
        d.low_ms = '0;
      end
      if (tick && q.win != 8'h0) begin
        d.win = q.win - 8'h1;
      end
      if (rise && q.win == 8'h0) begin
        d.win = window;
      end
      if ((low && q.low_ms >= min_width) || (fall && q.win != 8'h0)) begin
        d.fault = 1'b1;
        d.tripped = 1'b1;
        d.win = '0;
        d.low_ms = '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fault = q.fault;
  assign level = q.s2;

  property p_lock_quiet;
    @(posedge clk) disable iff (rst)
    q.lock != 8'h0 || !(&q.warm) |=> !q.fault;
  endproperty
  a_lock_quiet: assert property (p_lock_quiet) else $error("fault during lockout");

  property p_fault_powered;
    @(posedge clk) disable iff (rst)
    q.fault |-> $past(powered, 1) && $past(q.pwr, 1) && $past(q.s2, 1) == 1'b0;
  endproperty
  a_fault_powered: assert property (p_fault_powered) else $error("fault without power");

endmodule

// ### rtl/port_power_overcurrent_ctrl.sv
// Downstream port power control and over-current sensing, six ports.
// Assumes an Avalon-MM master and pin inputs synchronous to clk.
module port_power_overcurrent_ctrl #(
  parameter int TICK_CYCLES = port_power_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Hub logic power requests
  input wire logic [port_power_pkg::NPORTS-1:0] hub_port_power,
  // Per-port power/sense pins
  input wire logic [port_power_pkg::NPORTS-1:0] port_power_sense_pins_i,
  output logic [port_power_pkg::NPORTS-1:0] port_power_sense_pins_o,
  output logic [port_power_pkg::NPORTS-1:0] port_power_sense_pins_oe,
  output logic [port_power_pkg::NPORTS-1:0] port_pullup_en,
  // Shared power/sense pin
  input wire logic shared_power_sense_pin_i,
  output logic shared_power_sense_pin_o,
  output logic shared_power_sense_pin_oe,
  output logic shared_pullup_en,
  // Status
  output logic [port_power_pkg::NPORTS-1:0] over_current,
  output logic irq
);
  import port_power_pkg::*;

  localparam int NPINS = NPORTS + 1;

  typedef struct packed {
    logic [1:0] ctrl;
    logic [NPORTS-1:0] power;
    logic [NPORTS-1:0] charge;
    logic [NPORTS-1:0] status;
    logic [NPORTS-1:0] mask;
    logic [3:0] min_width;
    logic [7:0] inactive;
    logic [7:0] lockout;
    logic [NPINS-1:0] pin_on;
    logic [31:0] rdata;
    logic ack;
  } regs_s;

  localparam regs_s REGS_RST = '{
    ctrl: CTRL_RST,
    power: '0,
    charge: '0,
    status: '0,
    mask: '0,
    min_width: MIN_WIDTH_RST,
    inactive: INACTIVE_RST,
    lockout: LOCKOUT_RST,
    pin_on: '0,
    rdata: '0,
    ack: 1'b0
  };

  regs_s q, d;
  logic tick;
  logic [NPINS-1:0] pins_in;
  logic [NPINS-1:0] flt;
  logic [NPINS-1:0] lvl;
  logic [13:0] idx;
  logic req;
  logic wr_now;
  logic gang;
  logic [NPORTS-1:0] cmd;
  logic [NPORTS-1:0] want;
  logic [NPORTS-1:0] events;
  logic [NPORTS-1:0] w1c;
  logic [31:0] rd_mux;

  ms_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // Index NPORTS is the shared pin; one filter per pin
  assign pins_in = {shared_power_sense_pin_i, port_power_sense_pins_i};

  for (genvar g = 0; g < NPINS; g++) begin : g_filt
    port_fault_filter u_filt (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .min_width(q.min_width),
      .window(q.inactive),
      .lockout(q.lockout),
      .pin_i(pins_in[g]),
      .powered(q.pin_on[g]),
      .fault(flt[g]),
      .level(lvl[g])
    );
  end

  always_comb begin
    d = q;
    d.ack = 1'b0;
    idx = avs_address[15:2];
    req = (avs_read | avs_write) & ~q.ack;
    // A write lands on the edge where waitrequest is seen low
    wr_now = avs_write & q.ack & avs_byteenable[0];
    gang = q.ctrl[CTRL_GANG_BIT];

    // Power source: hub logic or processor register
    cmd = q.ctrl[CTRL_CPU_BIT] ? q.power : hub_port_power;
    // Charging ports keep their own pin, or the shared pin in gang mode, released to flag the external supply
    want = cmd | q.charge;
    d.pin_on[NPORTS-1:0] = gang ? '0 : want;
    d.pin_on[NPORTS] = gang & (|want);

    events = gang ? {NPORTS{flt[NPORTS]}} : flt[NPORTS-1:0];

    rd_mux = '0;
    case (idx)
      IDX_LOCKOUT: rd_mux[7:0] = q.lockout;
      IDX_MIN_WIDTH: rd_mux[3:0] = q.min_width;
      IDX_INACTIVE: rd_mux[7:0] = q.inactive;
      IDX_CTRL: rd_mux[1:0] = q.ctrl;
      IDX_POWER: rd_mux[NPORTS-1:0] = q.power;
      IDX_CHARGE: rd_mux[NPORTS-1:0] = q.charge;
      IDX_STATUS: rd_mux[NPORTS-1:0] = q.status;
      IDX_MASK: rd_mux[NPORTS-1:0] = q.mask;
      IDX_PINS: begin
        rd_mux[NPINS-1:0] = lvl;
        rd_mux[PINS_ON_POS +: NPINS] = q.pin_on;
      end
      default: rd_mux = '0;
    endcase
    if (req) begin
      d.ack = 1'b1;
      if (avs_read) begin
        d.rdata = rd_mux;
      end
    end

    w1c = '0;
    if (wr_now) begin
      case (idx)
        IDX_LOCKOUT: d.lockout = avs_writedata[7:0];
        IDX_MIN_WIDTH: begin
          // Values past the top step saturate rather than wrap
          if (avs_writedata[3:0] > MIN_WIDTH_MAX) begin
            d.min_width = MIN_WIDTH_MAX;
          end else begin
            d.min_width = avs_writedata[3:0];
          end
        end
        IDX_INACTIVE: d.inactive = avs_writedata[7:0];
        IDX_CTRL: d.ctrl = avs_writedata[1:0];
        IDX_POWER: d.power = avs_writedata[NPORTS-1:0];
        IDX_CHARGE: d.charge = avs_writedata[NPORTS-1:0];
        IDX_STATUS: w1c = avs_writedata[NPORTS-1:0];
        IDX_MASK: d.mask = avs_writedata[NPORTS-1:0];
        default: w1c = '0;
      endcase
    end
    // A new event outranks a clear in the same cycle
    d.status = (q.status & ~w1c) | events;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
  assign avs_readdata = q.rdata;

  // Pin never drives high; off means driven low, on means released
  assign port_power_sense_pins_o = '0;
  assign port_power_sense_pins_oe = ~q.pin_on[NPORTS-1:0];
  assign port_pullup_en = q.pin_on[NPORTS-1:0];
  assign shared_power_sense_pin_o = 1'b0;
  assign shared_power_sense_pin_oe = ~q.pin_on[NPORTS];
  assign shared_pullup_en = q.pin_on[NPORTS];

  assign over_current = q.status;
  assign irq = |(q.status & q.mask);

  property p_gang_spread;
    @(posedge clk) disable iff (rst)
    q.ctrl[CTRL_GANG_BIT] && flt[NPORTS] |=> &q.status;
  endproperty
  a_gang_spread: assert property (p_gang_spread) else $error("gang fault not spread");

  property p_shared_gang;
    @(posedge clk) disable iff (rst)
    q.pin_on[NPORTS] |-> $past(q.ctrl[CTRL_GANG_BIT]) && port_power_sense_pins_oe == '1;
  endproperty
  a_shared_gang: assert property (p_shared_gang) else $error("shared pin on outside gang");

  property p_drive_low;
    @(posedge clk) disable iff (rst)
    !q.ctrl[CTRL_GANG_BIT] && !q.ctrl[CTRL_CPU_BIT] && !hub_port_power[0] && !q.charge[0]
      |=> port_power_sense_pins_oe[0] && !port_pullup_en[0];
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("off port not driven low");

  property p_release_on;
    @(posedge clk) disable iff (rst)
    !q.ctrl[CTRL_GANG_BIT] && !q.ctrl[CTRL_CPU_BIT] && hub_port_power[0]
      |=> !port_power_sense_pins_oe[0] && port_pullup_en[0];
  endproperty
  a_release_on: assert property (p_release_on) else $error("on port not released");

  property p_event_set;
    @(posedge clk) disable iff (rst)
    !q.ctrl[CTRL_GANG_BIT] && flt[0] |=> q.status[0];
  endproperty
  a_event_set: assert property (p_event_set) else $error("port fault not flagged");

  property p_width_clamp;
    @(posedge clk) disable iff (rst)
    wr_now && idx == IDX_MIN_WIDTH |=> q.min_width <= MIN_WIDTH_MAX;
  endproperty
  a_width_clamp: assert property (p_width_clamp) else $error("min width out of range");

  property p_wait_one;
    @(posedge clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest held too long");

  // Pin direction per mode and power source
  property p_never_high;
    @(posedge clk) disable iff (rst)
    port_power_sense_pins_o == '0 && !shared_power_sense_pin_o;
  endproperty
  a_never_high: assert property (p_never_high) else $error("pin driven high");

  property p_indiv_shared_low;
    @(posedge clk) disable iff (rst)
    !q.ctrl[CTRL_GANG_BIT] |=> shared_power_sense_pin_oe && !shared_pullup_en;
  endproperty
  a_indiv_shared_low: assert property (p_indiv_shared_low) else $error("shared pin on");

  property p_gang_ports_low;
    @(posedge clk) disable iff (rst)
    q.ctrl[CTRL_GANG_BIT] |=> port_power_sense_pins_oe == '1 && port_pullup_en == '0;
  endproperty
  a_gang_ports_low: assert property (p_gang_ports_low) else $error("port pin on in gang");

  property p_gang_any_on;
    @(posedge clk) disable iff (rst)
    q.ctrl[CTRL_GANG_BIT] |=> shared_pullup_en == $past(|want);
  endproperty
  a_gang_any_on: assert property (p_gang_any_on) else $error("shared pin state wrong");

  property p_hub_power;
    @(posedge clk) disable iff (rst)
    !q.ctrl[CTRL_GANG_BIT] && !q.ctrl[CTRL_CPU_BIT]
      |=> port_pullup_en == $past(hub_port_power | q.charge);
  endproperty
  a_hub_power: assert property (p_hub_power) else $error("hub power not followed");

  property p_cpu_power;
    @(posedge clk) disable iff (rst)
    !q.ctrl[CTRL_GANG_BIT] && q.ctrl[CTRL_CPU_BIT]
      |=> port_pullup_en == $past(q.power | q.charge);
  endproperty
  a_cpu_power: assert property (p_cpu_power) else $error("cpu power not followed");

  property p_charge_on;
    @(posedge clk) disable iff (rst)
    !q.ctrl[CTRL_GANG_BIT] && q.charge != '0
      |=> (port_pullup_en & $past(q.charge)) == $past(q.charge);
  endproperty
  a_charge_on: assert property (p_charge_on) else $error("charging port not on");

  // Status flags and configuration
  property p_indiv_events;
    @(posedge clk) disable iff (rst)
    !q.ctrl[CTRL_GANG_BIT]
      |=> (q.status & $past(flt[NPORTS-1:0])) == $past(flt[NPORTS-1:0]);
  endproperty
  a_indiv_events: assert property (p_indiv_events) else $error("port fault lost");

  property p_gang_ignores_ports;
    @(posedge clk) disable iff (rst)
    q.ctrl[CTRL_GANG_BIT] && !flt[NPORTS] |=> (q.status & ~$past(q.status)) == '0;
  endproperty
  a_gang_ignores_ports: assert property (p_gang_ignores_ports) else $error("stray gang flag");

  property p_status_sticky;
    @(posedge clk) disable iff (rst)
    !wr_now |=> (q.status & $past(q.status)) == $past(q.status);
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

  property p_clear_bit;
    @(posedge clk) disable iff (rst)
    wr_now && idx == IDX_STATUS |=> (q.status & $past(w1c & ~events)) == '0;
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("status bit not cleared");

  property p_set_wins;
    @(posedge clk) disable iff (rst)
    (events & w1c) != '0
      |=> (q.status & $past(events & w1c)) == $past(events & w1c);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");

  property p_ctrl_write;
    @(posedge clk) disable iff (rst)
    wr_now && idx == IDX_CTRL |=> q.ctrl == $past(avs_writedata[1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

  property p_ctrl_only_bus;
    @(posedge clk) disable iff (rst)
    !(wr_now && idx == IDX_CTRL) |=> $stable(q.ctrl);
  endproperty
  a_ctrl_only_bus: assert property (p_ctrl_only_bus) else $error("mode changed alone");

  property p_read_data;
    @(posedge clk) disable iff (rst)
    avs_read && !avs_waitrequest |-> avs_readdata == $past(rd_mux);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not captured");

endmodule

// ### testbench/power_switch_model.sv
// External port power switches with open-drain fault outputs, one per pin.
// Assumes oe and pull-up enables from the hub; index 6 is the shared pin.
module power_switch_model (
  // Clock
  input wire logic clk,
  // Hub side
  input wire logic [6:0] oe,
  input wire logic [6:0] pu,
  input wire logic gang,
  // Fault commands from the bench
  input wire logic [6:0] fault,
  // Resolved pin levels and switch enables
  output logic [6:0] pin,
  output logic [5:0] sw_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'b0;
  always @(posedge clk) tog <= ~tog;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      // Undriven pin wanders so a stale level is never trusted
      pin[i] = oe[i] ? 1'b0 : fault[i] ? 1'b0 : pu[i] ? 1'b1 : tog;
    end
  end
  assign sw_en = gang ? {6{pin[6]}} : pin[5:0];
endmodule

// ### testbench/port_power_overcurrent_ctrl_tb.sv
// Self-checking bench for the port power and over-current block.
// Assumes a fast tick parameter so millisecond timing fits a short run.
module port_power_overcurrent_ctrl_tb;
  import port_power_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  logic clk = 1'b0, rst = 1'b1;
  logic [15:0] avs_address = 16'h0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, irq, sh_o, sh_oe, sh_pu;
  logic [5:0] hub_port_power = 6'h0, p_o, p_oe, p_pu, over_current;
  logic [6:0] pin, fault_q = 7'h0;
  logic [5:0] sw_en;
  logic gang_q = 1'b0;
  logic [31:0] seed = 32'd31118;
  int n_errors = 0, checks_done = 0, k, j;
  logic [5:0] r;

  port_power_overcurrent_ctrl #(.TICK_CYCLES(TK)) dut_u (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hub_port_power(hub_port_power), .port_power_sense_pins_i(pin[5:0]),
    .port_power_sense_pins_o(p_o), .port_power_sense_pins_oe(p_oe),
    .port_pullup_en(p_pu), .shared_power_sense_pin_i(pin[6]),
    .shared_power_sense_pin_o(sh_o), .shared_power_sense_pin_oe(sh_oe),
    .shared_pullup_en(sh_pu), .over_current(over_current), .irq(irq));
  power_switch_model sw_u (.clk(clk), .oe({sh_oe, p_oe}), .pu({sh_pu, p_pu}),
    .gang(gang_q), .fault(fault_q), .pin(pin), .sw_en(sw_en));

  initial begin
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(logic w, logic [13:0] i, logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {i, 2'b00};
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) chk("waitrequest", 0, 1);
  endtask

  task automatic wr(logic [13:0] i, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask

  task automatic rdc(string nm, logic [13:0] i, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, i, 32'h0, q);
    chk(nm, e, q);
  endtask

  task automatic pulse(int p, int n);
    fault_q[p] <= 1'b1;
    cyc(n);
    fault_q[p] <= 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    n_errors++;
    print_verdict();
  end

  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(1);
    chk("oe after reset", 7'h7f, {sh_oe, p_oe});
    chk("pullup after reset", 7'h0, {sh_pu, p_pu});
    chk("pin out low", 7'h0, {sh_o, p_o});
    rdc("lockout", IDX_LOCKOUT, 32'h0a);
    rdc("min width", IDX_MIN_WIDTH, 32'h5);
    rdc("window", IDX_INACTIVE, 32'h14);
    rdc("ctrl", IDX_CTRL, 32'h0);
    wr(IDX_MIN_WIDTH, 32'h9);
    rdc("min width sat", IDX_MIN_WIDTH, 32'h5);
    wr(14'h0000, 32'hff);
    rdc("unmapped", 14'h0000, 32'h0);
    avs_byteenable <= 4'he;
    wr(IDX_LOCKOUT, 32'h33);
    avs_byteenable <= 4'hf;
    rdc("lane off", IDX_LOCKOUT, 32'h0a);
    $display("test registers done");

    for (int t = 0; t < 4; t++) begin
      r = 6'(xs());
      hub_port_power <= r;
      cyc(3);
      chk("hub oe", 6'(~r), p_oe);
      chk("hub pullup", r, p_pu);
      chk("shared oe", 1, sh_oe);
    end
    r = 6'(xs());
    wr(IDX_CTRL, 32'h2);
    wr(IDX_POWER, {26'h0, r});
    hub_port_power <= ~r;
    cyc(3);
    chk("cpu pullup", r, p_pu);
    wr(IDX_POWER, 32'h0);
    wr(IDX_CHARGE, 32'h21);
    cyc(3);
    chk("charge pullup", 6'h21, p_pu);
    wr(IDX_CHARGE, 32'h0);
    $display("test power done");

    k = xs() % 6;
    wr(IDX_MIN_WIDTH, 32'h0);
    wr(IDX_LOCKOUT, 32'h4);
    wr(IDX_POWER, 32'h1 << k);
    cyc(4);
    pulse(k, 40);
    cyc(80);
    chk("lockout", 6'h0, over_current);
    wr(IDX_MIN_WIDTH, 32'h5);
    pulse(k, 5);
    cyc(20);
    chk("short low", 6'h0, over_current);
    cyc(40);
    pulse(k, 5);
    cyc(10);
    chk("double low", 6'h1 << k, over_current);
    chk("irq masked", 0, irq);
    wr(IDX_MASK, 32'h1 << k);
    cyc(1);
    chk("irq", 1, irq);
    wr(IDX_STATUS, 32'h1 << k);
    cyc(1);
    chk("w1c", 6'h0, over_current);
    chk("irq clear", 0, irq);
    $display("test double done");

    j = (k + 1) % 6;
    wr(IDX_POWER, 32'h0);
    wr(IDX_POWER, 32'h1 << j);
    cyc(100);
    pulse(j, 140);
    cyc(10);
    chk("single low", 6'h1 << j, over_current);
    wr(IDX_STATUS, 32'h3f);
    $display("test single done");

    wr(IDX_POWER, 32'h0);
    wr(IDX_CTRL, 32'h3);
    gang_q <= 1'b1;
    wr(IDX_POWER, 32'h3f);
    cyc(3);
    chk("gang ports oe", 6'h3f, p_oe);
    chk("gang shared on", 1, sh_pu);
    chk("gang switch enables", 6'h3f, sw_en);
    rdc("pins", IDX_PINS, (32'h40 << PINS_ON_POS) | 32'h40);
    cyc(100);
    pulse(6, 140);
    cyc(10);
    chk("gang fault", 6'h3f, over_current);
    $display("test gang done");

    rst <= 1'b1;
    gang_q <= 1'b0;
    hub_port_power <= 6'h0;
    cyc(2);
    rst <= 1'b0;
    cyc(1);
    chk("status after reset", 6'h0, over_current);
    chk("irq after reset", 0, irq);
    chk("oe after second reset", 7'h7f, {sh_oe, p_oe});
    rdc("ctrl after reset", IDX_CTRL, 32'h0);
    $display("test reset done");
    print_verdict();
  end
endmodule
